// file: hdl/emps_pkg.sv
// Register map, field positions, reset values and timing counts for the
// external memory port status block.
// Assumes a 10 MHz CPU clock and a 32-bit AXI4-Lite register bus.
package emps_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [15:0] IDX_DATA_CFG   = 16'h0200;
   localparam logic [15:0] IDX_DATA_ERR   = 16'h0202;
   localparam logic [15:0] IDX_FETCH_ERR  = 16'h0302;
   localparam logic [15:0] IDX_SYS_CFG    = 16'h07fd;
   localparam logic [15:0] IDX_TO_CTRL    = 16'h9000;
   localparam logic [15:0] IDX_IDLE_CTRL  = 16'h0001;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h0010;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h0011;

   localparam logic [31:0] A_DATA_CFG   = {14'h0000, IDX_DATA_CFG, 2'h0};
   localparam logic [31:0] A_DATA_ERR   = {14'h0000, IDX_DATA_ERR, 2'h0};
   localparam logic [31:0] A_FETCH_ERR  = {14'h0000, IDX_FETCH_ERR, 2'h0};
   localparam logic [31:0] A_SYS_CFG    = {14'h0000, IDX_SYS_CFG, 2'h0};
   localparam logic [31:0] A_TO_CTRL    = {14'h0000, IDX_TO_CTRL, 2'h0};
   localparam logic [31:0] A_IDLE_CTRL  = {14'h0000, IDX_IDLE_CTRL, 2'h0};
   localparam logic [31:0] A_IRQ_STATUS = {14'h0000, IDX_IRQ_STATUS, 2'h0};
   localparam logic [31:0] A_IRQ_MASK   = {14'h0000, IDX_IRQ_MASK, 2'h0};

   // Field positions
   localparam int WPE_BIT       = 7;
   localparam int DATA_TO_BIT   = 12;
   localparam int FETCH_TO_BIT  = 12;
   localparam int CACHE_OK_BIT  = 5;
   localparam int CFG_RSVD_BIT  = 4;
   localparam int TO_EN_BIT     = 1;
   localparam int IDLE_REQ_BIT  = 0;
   localparam int IRQ_DATA_TO   = 0;
   localparam int IRQ_FETCH_TO  = 1;
   localparam int IRQ_IDLE_ERR  = 2;

   // Reset values
   localparam logic       WPE_RST      = 1'b0;
   localparam logic       CFG_RSVD_RST = 1'b0;
   localparam logic       TO_EN_RST    = 1'b0;
   localparam logic [9:0] CFG_HI_VAL   = 10'h208;
   localparam logic [2:0] IRQ_RST      = 3'h0;

   // Stall limit in CPU clock cycles
   localparam int          TO_CYCLES = 512;
   localparam logic [9:0]  TO_LIMIT  = 10'(TO_CYCLES);

   localparam int          ADDR_W = 24;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {FP_READY, FP_WAIT, FP_SLEEP} emps_fetch_t;
endpackage

// file: hdl/emps_timeout.sv
// Stall watchdog: pulses once when a stall outlasts the limit.
// Assumes stall_i stays high for the whole of one stalled access.
`timescale 1ns/1ns
module emps_timeout
   import emps_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic en_i,
   input  wire logic stall_i,
   output logic      hit_o
);
   logic [9:0] cnt;

   // Saturating one past the limit keeps a long stall from hitting twice
   assign hit_o = en_i && stall_i && (cnt == TO_LIMIT);

   always_ff @(posedge clk_i) begin
      if (!nrst_i || !en_i || !stall_i) begin
         cnt <= 10'h000;
      end else if (cnt != TO_LIMIT + 10'h001) begin
         cnt <= cnt + 10'h001;
      end
   end

   stall_length_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      hit_o |-> $past(en_i && stall_i, 512))
      else $error("time-out declared before 512 stalled cycles");
endmodule

// file: hdl/emps_top.sv
// Data-side write posting and fetch-port control with their error status,
// reached over AXI4-Lite.
// Assumes CPU, cache and external memory interface share clk_i.
// Behaviour
// - Bit 7 enables write posting, reset 0
// - Two posting slots; stall only when both full
// - Read-only data time-out flag at bit 12
// - Fetch port carries cache requests, returns data
// - Read-only fetch time-out flag at bit 12
// - Fetch time-outs only while time-out enabled
// - Time-out after more than 512 stalled cycles
// - Idle bit plus idle instruction requests idle
// - Enter idle only with no cache request
// - Idle port ignores and never answers requests
// - Bus error when idled without CPU idle
// - Bit 5 shows cache working, reset 0
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module emps_top
   import emps_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic [31:0]       awaddr_i,
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   output logic [1:0]             bresp_o,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [31:0]       araddr_i,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   output logic [31:0]            rdata_o,
   output logic [1:0]             rresp_o,
   output logic                   rvalid_o,
   input  wire logic              rready_i,
   output logic                   irq_o,
   input  wire logic              dwr_valid_i,
   input  wire logic [ADDR_W-1:0] dwr_addr_i,
   input  wire logic [15:0]       dwr_data_i,
   output logic                   dwr_ready_o,
   input  wire logic              dmem_stall_i,
   output logic                   external_memory_interface_wr_valid_o,
   output logic [ADDR_W-1:0]      external_memory_interface_wr_addr_o,
   output logic [15:0]            external_memory_interface_wr_data_o,
   input  wire logic              external_memory_interface_wr_ready_i,
   input  wire logic              ic_req_i,
   input  wire logic [ADDR_W-1:0] ic_addr_i,
   output logic                   ic_rvalid_o,
   output logic [31:0]            ic_rdata_o,
   output logic                   fetch_req_o,
   output logic [ADDR_W-1:0]      fetch_addr_o,
   input  wire logic              fetch_ack_i,
   input  wire logic [31:0]       fetch_data_i,
   input  wire logic              idle_instr_i,
   input  wire logic              cpu_idle_i,
   output logic                   fetch_idle_o,
   output logic                   idle_bus_err_o,
   input  wire logic              cache_ok_i
);
   // Register state
   logic        write_posting_enable;
   logic        cfg_rsvd;
   logic        ext_memory_timeout_enable;
   logic        fetch_port_idle_request;
   logic        data_port_timeout_flag;
   logic        cache_fetch_timeout_flag;
   logic        cache_working_flag;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;

   // Bus slave holding state
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic        w_lane0;
   logic        wr_fire;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic        rd_hit;
   logic        ar_take;

   // Posting slots; slot 0 is the one offered to the memory interface
   logic                v1;
   logic [ADDR_W-1:0]   a1;
   logic [15:0]         d1;
   logic                n_v0;
   logic                n_v1;
   logic [ADDR_W-1:0]   n_a0;
   logic [ADDR_W-1:0]   n_a1;
   logic [15:0]         n_d0;
   logic [15:0]         n_d1;
   logic                push;
   logic                pop;
   logic                next_ready;

   // Fetch port
   emps_fetch_t fstate;
   emps_fetch_t next_fstate;
   logic        idle_pend;
   logic        enter_sleep;
   logic        data_hit;
   logic        fetch_hit;
   logic        data_stall;
   logic        fetch_stall;
   logic [2:0]  irq_event;
   logic [2:0]  irq_clear;

   // Register writes
   assign wr_fire = !awready_o && !wready_o && !bvalid_o;
   assign wr_hit  = (aw_addr == A_DATA_CFG) || (aw_addr == A_SYS_CFG) ||
                    (aw_addr == A_TO_CTRL) || (aw_addr == A_IDLE_CTRL) ||
                    (aw_addr == A_IRQ_STATUS) || (aw_addr == A_IRQ_MASK) ||
                    (aw_addr == A_DATA_ERR) || (aw_addr == A_FETCH_ERR);
   assign irq_clear = (wr_fire && w_lane0 && aw_addr == A_IRQ_STATUS) ? w_data[2:0] : 3'h0;

   // Register reads; unnamed bits are zero except the fixed upper config field
   assign ar_take = arvalid_i && arready_o;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (araddr_i == A_DATA_CFG) begin
         rd_word[WPE_BIT] = write_posting_enable;
      end else if (araddr_i == A_DATA_ERR) begin
         rd_word[DATA_TO_BIT] = data_port_timeout_flag;
      end else if (araddr_i == A_FETCH_ERR) begin
         rd_word[FETCH_TO_BIT] = cache_fetch_timeout_flag;
      end else if (araddr_i == A_SYS_CFG) begin
         rd_word[15:6]         = CFG_HI_VAL;
         rd_word[CACHE_OK_BIT] = cache_working_flag;
         rd_word[CFG_RSVD_BIT] = cfg_rsvd;
      end else if (araddr_i == A_TO_CTRL) begin
         rd_word[TO_EN_BIT] = ext_memory_timeout_enable;
      end else if (araddr_i == A_IDLE_CTRL) begin
         rd_word[IDLE_REQ_BIT] = fetch_port_idle_request;
      end else if (araddr_i == A_IRQ_STATUS) begin
         rd_word[2:0] = irq_status;
      end else if (araddr_i == A_IRQ_MASK) begin
         rd_word[2:0] = irq_mask;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         awready_o <= 1'b1;
         wready_o  <= 1'b1;
         bvalid_o  <= 1'b0;
         bresp_o   <= RESP_OKAY;
         aw_addr   <= 32'h0000_0000;
         w_data    <= 32'h0000_0000;
         w_lane0   <= 1'b0;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_addr   <= awaddr_i;
            awready_o <= 1'b0;
         end
         if (wvalid_i && wready_o) begin
            w_data   <= wdata_i;
            w_lane0  <= wstrb_i[0];
            wready_o <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_o  <= 1'b1;
            bresp_o   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         arready_o <= 1'b1;
         rvalid_o  <= 1'b0;
         rdata_o   <= 32'h0000_0000;
         rresp_o   <= RESP_OKAY;
      end else if (ar_take) begin
         arready_o <= 1'b0;
         rvalid_o  <= 1'b1;
         rdata_o   <= rd_word;
         rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
         arready_o <= 1'b1;
         rvalid_o  <= 1'b0;
      end
   end

   // Writable fields; error flags and the cache bit take no bus writes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         write_posting_enable      <= WPE_RST;
         cfg_rsvd                  <= CFG_RSVD_RST;
         ext_memory_timeout_enable <= TO_EN_RST;
         irq_mask                  <= IRQ_RST;
      end else if (wr_fire && w_lane0) begin
         if (aw_addr == A_DATA_CFG) begin
            write_posting_enable <= w_data[WPE_BIT];
         end
         if (aw_addr == A_SYS_CFG) begin
            cfg_rsvd <= w_data[CFG_RSVD_BIT];
         end
         if (aw_addr == A_TO_CTRL) begin
            ext_memory_timeout_enable <= w_data[TO_EN_BIT];
         end
         if (aw_addr == A_IRQ_MASK) begin
            irq_mask <= w_data[2:0];
         end
      end
   end

   wpe_write_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_fire && w_lane0 && aw_addr == A_DATA_CFG)
         |=> write_posting_enable == $past(w_data[WPE_BIT]))
      else $error("posting enable did not take the written bit");

   // Write posting
   assign pop  = external_memory_interface_wr_valid_o && external_memory_interface_wr_ready_i;
   assign push = dwr_valid_i && dwr_ready_o;
   always_comb begin
      n_v0 = external_memory_interface_wr_valid_o;
      n_a0 = external_memory_interface_wr_addr_o;
      n_d0 = external_memory_interface_wr_data_o;
      n_v1 = v1;
      n_a1 = a1;
      n_d1 = d1;
      if (pop) begin
         n_v0 = v1;
         n_a0 = a1;
         n_d0 = d1;
         n_v1 = 1'b0;
      end
      if (push && !n_v0) begin
         n_v0 = 1'b1;
         n_a0 = dwr_addr_i;
         n_d0 = dwr_data_i;
      end else if (push) begin
         n_v1 = 1'b1;
         n_a1 = dwr_addr_i;
         n_d1 = dwr_data_i;
      end
   end
   // Without posting the CPU waits for the previous write to leave
   assign next_ready = write_posting_enable ? !(n_v0 && n_v1) : !n_v0;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         external_memory_interface_wr_valid_o <= 1'b0;
         external_memory_interface_wr_addr_o  <= '0;
         external_memory_interface_wr_data_o  <= 16'h0000;
         v1              <= 1'b0;
         a1              <= '0;
         d1              <= 16'h0000;
         dwr_ready_o     <= 1'b0;
      end else begin
         external_memory_interface_wr_valid_o <= n_v0;
         external_memory_interface_wr_addr_o  <= n_a0;
         external_memory_interface_wr_data_o  <= n_d0;
         v1              <= n_v1;
         a1              <= n_a1;
         d1              <= n_d1;
         dwr_ready_o     <= next_ready;
      end
   end

   post_full_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (external_memory_interface_wr_valid_o && v1) |-> !dwr_ready_o)
      else $error("write accepted with both posting slots full");
   post_free_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (write_posting_enable && !external_memory_interface_wr_valid_o && !v1) |-> dwr_ready_o)
      else $error("posting stalled with free slots");

   // Time-out watchdogs
   assign data_stall  = (external_memory_interface_wr_valid_o && !external_memory_interface_wr_ready_i) || dmem_stall_i;
   assign fetch_stall = fetch_req_o && !fetch_ack_i;

   emps_timeout u_data_to (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .en_i    (ext_memory_timeout_enable),
      .stall_i (data_stall),
      .hit_o   (data_hit)
   );

   emps_timeout u_fetch_to (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .en_i    (ext_memory_timeout_enable),
      .stall_i (fetch_stall),
      .hit_o   (fetch_hit)
   );

   // Fetch port sequencing
   assign enter_sleep = (fstate == FP_READY) && idle_pend && !ic_req_i;
   always_comb begin
      next_fstate = fstate;
      case (fstate)
         FP_READY: begin
            if (enter_sleep) begin
               next_fstate = FP_SLEEP;
            end else if (ic_req_i && !ic_rvalid_o) begin
               next_fstate = FP_WAIT;
            end
         end
         FP_WAIT: begin
            if (fetch_ack_i) begin
               next_fstate = FP_READY;
            end
         end
         FP_SLEEP: begin
            // Requests stay unanswered until software drops the idle bit
            if (!fetch_port_idle_request) begin
               next_fstate = FP_READY;
            end
         end
         default: next_fstate = FP_READY;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         fstate         <= FP_READY;
         fetch_req_o    <= 1'b0;
         fetch_addr_o   <= '0;
         ic_rvalid_o    <= 1'b0;
         ic_rdata_o     <= 32'h0000_0000;
         fetch_idle_o   <= 1'b0;
         idle_bus_err_o <= 1'b0;
      end else begin
         fstate         <= next_fstate;
         fetch_idle_o   <= (next_fstate == FP_SLEEP);
         idle_bus_err_o <= enter_sleep && !cpu_idle_i;
         ic_rvalid_o    <= (fstate == FP_WAIT) && fetch_ack_i;
         if ((fstate == FP_WAIT) && fetch_ack_i) begin
            ic_rdata_o <= fetch_data_i;
         end
         if (next_fstate == FP_WAIT && fstate == FP_READY) begin
            fetch_req_o  <= 1'b1;
            fetch_addr_o <= ic_addr_i;
         end else if (fetch_ack_i) begin
            fetch_req_o <= 1'b0;
         end
      end
   end

   // Idle request: control bit armed, then the idle instruction
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         fetch_port_idle_request <= 1'b0;
         idle_pend               <= 1'b0;
      end else begin
         if (wr_fire && w_lane0 && aw_addr == A_IDLE_CTRL) begin
            fetch_port_idle_request <= w_data[IDLE_REQ_BIT];
         end
         if (enter_sleep || !fetch_port_idle_request) begin
            idle_pend <= 1'b0;
         end else if (idle_instr_i) begin
            idle_pend <= 1'b1;
         end
      end
   end

   fetch_return_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (fstate == FP_WAIT && fetch_ack_i) |=> ic_rvalid_o && ic_rdata_o == $past(fetch_data_i))
      else $error("fetched data not returned to the cache");
   sleep_entry_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (fstate != FP_SLEEP && next_fstate == FP_SLEEP) |-> !ic_req_i && idle_pend)
      else $error("fetch port idled with a request pending");
   sleep_quiet_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (fstate == FP_SLEEP && $past(fstate == FP_SLEEP)) |-> !ic_rvalid_o && !fetch_req_o)
      else $error("idle fetch port answered a request");
   idle_error_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (enter_sleep && !cpu_idle_i) |=> idle_bus_err_o ##1 !idle_bus_err_o || enter_sleep)
      else $error("no bus error when idled without CPU idle");

   // Status flags, cache health and interrupt
   assign irq_event = {enter_sleep && !cpu_idle_i, fetch_hit, data_hit};
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         data_port_timeout_flag   <= 1'b0;
         cache_fetch_timeout_flag <= 1'b0;
         cache_working_flag       <= 1'b0;
         irq_status               <= IRQ_RST;
         irq_o                    <= 1'b0;
      end else begin
         data_port_timeout_flag   <= data_port_timeout_flag | data_hit;
         cache_fetch_timeout_flag <= cache_fetch_timeout_flag | fetch_hit;
         cache_working_flag       <= cache_ok_i;
         // A new event wins over a clear in the same cycle
         irq_status               <= (irq_status & ~irq_clear) | irq_event;
         irq_o                    <= |(irq_status & irq_mask);
      end
   end

   data_flag_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      data_hit |=> data_port_timeout_flag [*3])
      else $error("data time-out flag not set and held");
   fetch_flag_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      $rose(cache_fetch_timeout_flag) |-> $past(ext_memory_timeout_enable && fetch_stall))
      else $error("fetch time-out flagged with detection disabled");
   cfg_read_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      (ar_take && araddr_i == A_SYS_CFG)
         |=> rdata_o[15:6] == CFG_HI_VAL && rdata_o[3:0] == 4'h0 && rdata_o[31:16] == 16'h0000)
      else $error("configuration register read wrong fixed bits");
   irq_level_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
      ##1 irq_o == $past(|(irq_status & irq_mask)))
      else $error("interrupt output does not follow masked status");
endmodule

// file: testbench/emps_mem_model.sv
// Behavioural external memory interface for fetch and posted writes.
// Assumes the block holds each request until it is answered.
`timescale 1ns/1ns
module emps_mem_model (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        req_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [1:0]  lat_i,
   input  wire logic        hang_i,
   input  wire logic        wr_valid_i,
   input  wire logic        wr_hold_i,
   output logic             ack_o,
   output logic [31:0]      data_o,
   output logic             wr_ready_o
);
   logic [1:0]  wait_cnt;
   logic [31:0] tick;
   // Lines change every cycle outside an answer so stale words never match
   assign data_o = ack_o ? {8'h5a, addr_i} : tick;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ack_o      <= 1'b0;
         wr_ready_o <= 1'b0;
         wait_cnt   <= 2'h0;
         tick       <= 32'h0;
      end else begin
         tick       <= tick + 32'h1;
         wait_cnt   <= (req_i && !ack_o) ? wait_cnt + 2'h1 : 2'h0;
         ack_o      <= req_i && !ack_o && !hang_i && wait_cnt >= lat_i;
         wr_ready_o <= wr_valid_i && !wr_ready_o && !wr_hold_i;
      end
   end
endmodule

// file: testbench/test_external_memory_port_status.sv
// Self-checking bench for the external memory port status block.
// Assumes the memory model is compiled before this file.
`timescale 1ns/1ns
module test_external_memory_port_status
   import emps_pkg::*;
();
   logic        clk_i, nrst_i, awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
   logic        arvalid_i, arready_o, rvalid_o, rready_i, irq_o, dwr_valid_i, dwr_ready_o;
   logic        dmem_stall_i, external_memory_interface_wr_valid_o, external_memory_interface_wr_ready_i, ic_req_i, ic_rvalid_o;
   logic        fetch_req_o, fetch_ack_i, idle_instr_i, cpu_idle_i, fetch_idle_o;
   logic        idle_bus_err_o, cache_ok_i, hang, hold, seen;
   logic [31:0] awaddr_i, wdata_i, araddr_i, rdata_o, ic_rdata_o, fetch_data_i, rd;
   logic [23:0] dwr_addr_i, external_memory_interface_wr_addr_o, ic_addr_i, fetch_addr_o;
   logic [15:0] dwr_data_i, external_memory_interface_wr_data_o;
   logic [3:0]  wstrb_i;
   logic [1:0]  bresp_o, rresp_o, lat, rs, bs;
   logic [39:0] exp_q[$], got_q[$];
   int          err_total, n_compared, seed, k;

   emps_top dut_u (.clk_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
      .rdata_o, .rresp_o, .rvalid_o, .rready_i, .irq_o, .dwr_valid_i, .dwr_addr_i, .dwr_data_i,
      .dwr_ready_o, .dmem_stall_i, .external_memory_interface_wr_valid_o, .external_memory_interface_wr_addr_o, .external_memory_interface_wr_data_o,
      .external_memory_interface_wr_ready_i, .ic_req_i, .ic_addr_i, .ic_rvalid_o, .ic_rdata_o, .fetch_req_o,
      .fetch_addr_o, .fetch_ack_i, .fetch_data_i, .idle_instr_i, .cpu_idle_i, .fetch_idle_o,
      .idle_bus_err_o, .cache_ok_i);
   emps_mem_model mem_u (.clk_i, .nrst_i, .req_i(fetch_req_o), .addr_i(fetch_addr_o),
      .lat_i(lat), .hang_i(hang), .wr_valid_i(external_memory_interface_wr_valid_o), .wr_hold_i(hold),
      .ack_o(fetch_ack_i), .data_o(fetch_data_i), .wr_ready_o(external_memory_interface_wr_ready_i));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (external_memory_interface_wr_valid_o === 1'b1 && external_memory_interface_wr_ready_i === 1'b1)
         got_q.push_back({external_memory_interface_wr_addr_o, external_memory_interface_wr_data_o});
   end

   function automatic logic [31:0] sys_exp(input logic ok);
      return {16'h0, CFG_HI_VAL, ok, 5'h0};
   endfunction
   function automatic logic [31:0] fdat(input logic [23:0] a);
      return {8'h5a, a};
   endfunction
   task automatic conclude();
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      conclude();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic axw(input logic [31:0] a, d);
      int t;
      t = 0;
      awaddr_i  <= a;
      wdata_i   <= d;
      awvalid_i <= 1'b1;
      wvalid_i  <= 1'b1;
      bready_i  <= 1'b1;
      do begin
         @(posedge clk_i);
         t++;
         if (awready_o === 1'b1) awvalid_i <= 1'b0;
         if (wready_o === 1'b1) wvalid_i <= 1'b0;
         if (t > 50) tmo();
      end while (bvalid_o !== 1'b1);
      bs = bresp_o;
      bready_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic axr(input logic [31:0] a);
      int t;
      t = 0;
      araddr_i  <= a;
      arvalid_i <= 1'b1;
      rready_i  <= 1'b1;
      do begin
         @(posedge clk_i);
         t++;
         if (arready_o === 1'b1) arvalid_i <= 1'b0;
         if (t > 50) tmo();
      end while (rvalid_o !== 1'b1);
      rd = rdata_o;
      rs = rresp_o;
      rready_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdv(input logic [31:0] a, e);
      axr(a);
      chk(rd, e);
   endtask
   task automatic fwait(input logic [23:0] a);
      int t;
      t = 0;
      while (ic_rvalid_o !== 1'b1) begin
         @(posedge clk_i);
         t++;
         if (t > 40) tmo();
      end
      ic_req_i <= 1'b0;
      chk(ic_rdata_o, fdat(a));
   endtask
   // Memory side stalls all writes, so the accepted count shows the slot depth
   task automatic post(input logic on, input int slots);
      int acc;
      acc = 0;
      axw(A_DATA_CFG, {24'h0, on, 7'h0});
      hold        <= 1'b1;
      dwr_valid_i <= 1'b1;
      dwr_addr_i  <= 24'($random(seed));
      dwr_data_i  <= 16'($random(seed));
      repeat (10) begin
         @(posedge clk_i);
         if (dwr_ready_o === 1'b1) begin
            acc++;
            exp_q.push_back({dwr_addr_i, dwr_data_i});
            dwr_addr_i <= 24'($random(seed));
            dwr_data_i <= 16'($random(seed));
         end
      end
      dwr_valid_i <= 1'b0;
      chk(acc, slots);
      hold <= 1'b0;
      cyc(20);
      chk(got_q.size(), exp_q.size());
      while (exp_q.size() > 0 && got_q.size() > 0)
         chk(got_q.pop_front(), exp_q.pop_front());
   endtask

   initial begin
      seed = 5;
      err_total = 0;
      n_compared = 0;
      nrst_i = 1'b0;
      wstrb_i = 4'hf;
      {awaddr_i, wdata_i, araddr_i, dwr_addr_i, dwr_data_i, ic_addr_i, lat} = '0;
      {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, dwr_valid_i, dmem_stall_i} = '0;
      {ic_req_i, idle_instr_i, cpu_idle_i, cache_ok_i, hang, hold} = '0;
      cyc(5);
      nrst_i <= 1'b1;
      cyc(2);
      rdv(A_DATA_CFG, 32'h0);
      rdv(A_DATA_ERR, 32'h0);
      rdv(A_FETCH_ERR, 32'h0);
      rdv(A_SYS_CFG, sys_exp(1'b0));
      rdv(A_TO_CTRL, 32'h0);
      wstrb_i <= 4'h0;
      axw(A_DATA_CFG, 32'hff);
      wstrb_i <= 4'hf;
      rdv(A_DATA_CFG, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wdata_i <= $random(seed);
         cyc(1);
         axw(A_DATA_CFG, wdata_i);
         rdv(A_DATA_CFG, {24'h0, wdata_i[7], 7'h0});
      end
      axw(A_DATA_ERR, 32'hffffffff);
      axw(A_FETCH_ERR, 32'hffffffff);
      rdv(A_DATA_ERR, 32'h0);
      rdv(A_FETCH_ERR, 32'h0);
      cache_ok_i <= 1'b1;
      axw(A_SYS_CFG, 32'hffef);
      chk(bs, RESP_OKAY);
      rdv(A_SYS_CFG, sys_exp(1'b1));
      axr(32'h8);
      chk(rs, RESP_SLVERR);
      // An unmapped write is refused and leaves every register alone
      axw(32'h8, 32'h0);
      chk(bs, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         // Let an edge pass so the request line is never driven twice in one step
         cyc(1);
         lat <= 2'($random(seed));
         ic_addr_i <= 24'($random(seed));
         ic_req_i <= 1'b1;
         cyc(1);
         fwait(ic_addr_i);
      end
      post(1'b1, 2);
      post(1'b0, 1);
      hang <= 1'b1;
      dmem_stall_i <= 1'b1;
      ic_addr_i <= 24'h123;
      ic_req_i <= 1'b1;
      cyc(600);
      rdv(A_FETCH_ERR, 32'h0);
      axw(A_TO_CTRL, 32'h2);
      cyc(490);
      rdv(A_FETCH_ERR, 32'h0);
      rdv(A_DATA_ERR, 32'h0);
      cyc(30);
      rdv(A_FETCH_ERR, 32'h1000);
      rdv(A_DATA_ERR, 32'h1000);
      rdv(A_IRQ_STATUS, 32'h3);
      chk(irq_o, 1'b0);
      axw(A_IRQ_MASK, 32'h2);
      cyc(2);
      chk(irq_o, 1'b1);
      hang <= 1'b0;
      dmem_stall_i <= 1'b0;
      fwait(24'h123);
      axw(A_IRQ_STATUS, 32'h3);
      axw(A_TO_CTRL, 32'h0);
      rdv(A_IRQ_STATUS, 32'h0);
      chk(irq_o, 1'b0);
      for (int c = 0; c < 2; c++) begin
         cpu_idle_i <= c[0];
         axw(A_IDLE_CTRL, 32'h1);
         idle_instr_i <= 1'b1;
         cyc(1);
         idle_instr_i <= 1'b0;
         seen = 1'b0;
         k = 0;
         while (fetch_idle_o !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k++;
            if (idle_bus_err_o === 1'b1) seen = 1'b1;
         end
         if (fetch_idle_o !== 1'b1) tmo();
         chk(fetch_idle_o, 1'b1);
         chk(seen, !c[0]);
         ic_addr_i <= 24'h42;
         ic_req_i <= 1'b1;
         seen = 1'b0;
         repeat (30) begin
            @(posedge clk_i);
            if (fetch_req_o === 1'b1 || ic_rvalid_o === 1'b1) seen = 1'b1;
         end
         chk(seen, 1'b0);
         axw(A_IDLE_CTRL, 32'h0);
         fwait(24'h42);
      end
      rdv(A_IRQ_STATUS, 32'h4);
      conclude();
   end
endmodule
